// >>> design/hfm_cfg.svh
`ifndef HFM_CFG_SVH
`define HFM_CFG_SVH

// ----------------------------------------
// clocking and phase accumulators
// ----------------------------------------
`define HFM_CLK_HZ      64'd40000000
`define HFM_ACC_W       24
`define HFM_FREQ_INC(f) ((((f)) << `HFM_ACC_W) / `HFM_CLK_HZ)
`define HFM_MARK_HZ     64'd1200
`define HFM_SPACE_HZ    64'd2200
`define HFM_RATE0_HZ    64'd460800
`define HFM_RATE1_HZ    64'd921600
`define HFM_RATE2_HZ    64'd1840000
`define HFM_RATE3_HZ    64'd3680000

// ----------------------------------------
// supervisor hold time (least time, rounded up)
// ----------------------------------------
`define HFM_POR_MS      64'd30
`define HFM_POR_CYCLES  (((`HFM_POR_MS * `HFM_CLK_HZ) + 64'd999) / 64'd1000)

// ----------------------------------------
// demodulator: half period at the 1700 Hz midpoint
// ----------------------------------------
`define HFM_SPLIT_HZ    64'd1700
`define HFM_SPLIT_CYC   (`HFM_CLK_HZ / (64'd2 * `HFM_SPLIT_HZ))

// ----------------------------------------
// serial control word and configuration
// ----------------------------------------
`define HFM_SER_BITS    5'd24
`define HFM_SER_SEL     23
`define HFM_CFG_RST     8'h00
`define HFM_CFG_TX_EN   0
`define HFM_CFG_RX_EN   1
`define HFM_CFG_DAC_EN  2
`define HFM_CFG_RATE_LO 4
`define HFM_CFG_RATE_HI 5

// ----------------------------------------
// tone shaping
// ----------------------------------------
`define HFM_TONE_MID    8'h80
`define HFM_TRAP_CLIP   9'sd96

`endif

// >>> design/hfm_modem.sv
`timescale 1ns/1ps
`default_nettype none
`include "hfm_cfg.svh"

// What this block does
// - Modem clock output at one of four rates, chosen by configuration.
// - External clock strap lets the oscillator be powered down.
// - Reset output is open-drain active low, driven by the supervisor.
// - Reset stays low at least 30 ms after sense reaches threshold.
// - Carrier detect rises when the carrier comparator sees signal.
// - Carrier detect held low without sufficient received signal.
// - Line frames are 1200 baud, 11 bits; host times them.
// - Request-to-send high disconnects the transmitter.
// - Transmit level converted to tones bit by bit, no buffering.
// - Mark 1200 Hz, space 2200 Hz, derived from the clock.
// - Transmit output is a trapezoid waveform of fixed swing.
// - Demodulated bits may carry up to 12% bit-time jitter.
// - Reset returns every configuration bit to its reset value.
// - Serial port: clock, data, select; loads DAC and configuration.
// - Sigma-delta DAC single-bit output averages to loaded value.
// - Modulator targets 25 Hz signal bandwidth.
module hfm_modem #(
  parameter int unsigned POR_CYCLES = 32'(`HFM_POR_CYCLES),
  parameter int unsigned DAC_W      = 16
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // pins from outside
  input  wire hfm_pkg::hfm_pins_t pins,
  // supervisor reset, open drain
  output logic                   supervisor_reset_n_o,
  output logic                   supervisor_reset_n_oe,
  // host bit interface
  output logic                   carrier_detect_out,
  output logic                   rxd,
  // analog side
  output hfm_pkg::hfm_tone_t     analog_tone_out,
  output logic                   dac_out,
  output logic                   secondary_clock_out,
  output logic                   osc_power_down
);
  import hfm_pkg::*;
  localparam int AW = `HFM_ACC_W;
  localparam logic [AW-1:0] MARK_INC  = AW'(`HFM_FREQ_INC(`HFM_MARK_HZ));
  localparam logic [AW-1:0] SPACE_INC = AW'(`HFM_FREQ_INC(`HFM_SPACE_HZ));
  localparam logic [15:0]   SPLIT     = 16'(`HFM_SPLIT_CYC);
  localparam logic [31:0]   POR_LAST  = 32'(POR_CYCLES - 1);

  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  hfm_pins_t meta_q;
  hfm_pins_t pin_s;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '{txd: 1'b1, request_to_send_n: 1'b1, ser_sel_n: 1'b1, default: 1'b0};
      pin_s  <= '{txd: 1'b1, request_to_send_n: 1'b1, ser_sel_n: 1'b1, default: 1'b0};
    end else begin
      meta_q <= pins;
      pin_s  <= meta_q;
    end
  end

  // ----------------------------------------
  // supply supervisor
  // ----------------------------------------
  hfm_sv_state_t sv_q, sv_d;
  logic [31:0]   sv_cnt_q, sv_cnt_d;
  always_comb begin
    sv_d     = sv_q;
    sv_cnt_d = '0;
    case (sv_q)
      SV_HOLD: begin
        if (pin_s.supervisor_sense_input) begin
          sv_d = SV_WAIT;
        end
      end
      SV_WAIT: begin
        if (!pin_s.supervisor_sense_input) begin
          sv_d = SV_HOLD;
        end else if (sv_cnt_q == POR_LAST) begin
          sv_d = SV_RUN;
        end else begin
          sv_cnt_d = sv_cnt_q + 32'd1;
        end
      end
      SV_RUN: begin
        if (!pin_s.supervisor_sense_input) begin
          sv_d = SV_HOLD;
        end
      end
      default: sv_d = SV_HOLD;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sv_q     <= SV_HOLD;
      sv_cnt_q <= '0;
    end else begin
      sv_q     <= sv_d;
      sv_cnt_q <= sv_cnt_d;
    end
  end
  // pin is only ever pulled low; the pull-up is external
  assign supervisor_reset_n_o  = 1'b0;
  assign supervisor_reset_n_oe = (sv_q != SV_RUN);

  // ----------------------------------------
  // serial control port and configuration
  // ----------------------------------------
  logic             sclk_d1_q, sel_d1_q;
  logic [23:0]      sh_q, sh_d;
  logic [4:0]       nb_q, nb_d;
  logic [7:0]       cfg_q, cfg_d;
  logic [DAC_W-1:0] dac_val_q, dac_val_d;
  logic             sclk_rise, sel_rise;
  assign sclk_rise = pin_s.ser_clk & ~sclk_d1_q;
  assign sel_rise  = pin_s.ser_sel_n & ~sel_d1_q;
  always_comb begin
    sh_d      = sh_q;
    nb_d      = nb_q;
    cfg_d     = cfg_q;
    dac_val_d = dac_val_q;
    if (pin_s.ser_sel_n) begin
      nb_d = '0;
    end else if (sclk_rise) begin
      sh_d = {sh_q[22:0], pin_s.ser_data};
      if (nb_q != `HFM_SER_BITS) begin
        nb_d = nb_q + 5'd1;
      end
    end
    if (sel_rise && nb_q == `HFM_SER_BITS) begin
      if (sh_q[`HFM_SER_SEL]) begin
        cfg_d = sh_q[7:0];
      end else begin
        dac_val_d = sh_q[DAC_W-1:0];
      end
    end
    if (sv_q != SV_RUN) begin
      cfg_d = `HFM_CFG_RST;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d1_q <= 1'b0;
      sel_d1_q  <= 1'b1;
      sh_q      <= '0;
      nb_q      <= '0;
      cfg_q     <= `HFM_CFG_RST;
      dac_val_q <= '0;
    end else begin
      sclk_d1_q <= pin_s.ser_clk;
      sel_d1_q  <= pin_s.ser_sel_n;
      sh_q      <= sh_d;
      nb_q      <= nb_d;
      cfg_q     <= cfg_d;
      dac_val_q <= dac_val_d;
    end
  end

  // ----------------------------------------
  // modem clock, oscillator control, DAC
  // ----------------------------------------
  logic [AW-1:0]  mclk_acc_q, mclk_acc_d, rate_inc;
  logic [DAC_W:0] sd_acc_q, sd_acc_d;
  logic           mclk_q, osc_pd_q, dac_q;
  always_comb begin
    case (cfg_q[`HFM_CFG_RATE_HI:`HFM_CFG_RATE_LO])
      2'd0:    rate_inc = AW'(`HFM_FREQ_INC(`HFM_RATE0_HZ));
      2'd1:    rate_inc = AW'(`HFM_FREQ_INC(`HFM_RATE1_HZ));
      2'd2:    rate_inc = AW'(`HFM_FREQ_INC(`HFM_RATE2_HZ));
      default: rate_inc = AW'(`HFM_FREQ_INC(`HFM_RATE3_HZ));
    endcase
    mclk_acc_d = mclk_acc_q + rate_inc;
    // first-order modulator; the carry density follows the loaded value
    sd_acc_d = {1'b0, sd_acc_q[DAC_W-1:0]} + {1'b0, dac_val_q};
    if (!cfg_q[`HFM_CFG_DAC_EN]) begin
      sd_acc_d = '0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mclk_acc_q <= '0;
      sd_acc_q   <= '0;
      mclk_q     <= 1'b0;
      osc_pd_q   <= 1'b0;
      dac_q      <= 1'b0;
    end else begin
      mclk_acc_q <= mclk_acc_d;
      sd_acc_q   <= sd_acc_d;
      mclk_q     <= mclk_acc_q[AW-1];
      osc_pd_q   <= pin_s.ext_clk_sel;
      dac_q      <= sd_acc_d[DAC_W];
    end
  end
  assign secondary_clock_out = mclk_q;
  assign osc_power_down      = osc_pd_q;
  assign dac_out             = dac_q;

  // ----------------------------------------
  // transmitter: direct bit-to-tone conversion
  // ----------------------------------------
  logic [AW-1:0] ph_q, ph_d;
  logic          tx_on;
  logic [8:0]    fold;
  logic signed [8:0] tri_s, clip_s;
  hfm_tone_t     tone_q, tone_d;
  assign tx_on = ~pin_s.request_to_send_n & cfg_q[`HFM_CFG_TX_EN];
  always_comb begin
    // accumulator never restarts, so tone changes keep phase
    ph_d = ph_q + (pin_s.txd ? MARK_INC : SPACE_INC);
    fold  = ph_q[AW-1] ? ~ph_q[AW-2:AW-10] : ph_q[AW-2:AW-10];
    tri_s = $signed(fold ^ 9'h100);
    if (tri_s > `HFM_TRAP_CLIP) begin
      clip_s = `HFM_TRAP_CLIP;
    end else if (tri_s < -`HFM_TRAP_CLIP) begin
      clip_s = -`HFM_TRAP_CLIP;
    end else begin
      clip_s = tri_s;
    end
    tone_d.enable = tx_on;
    tone_d.level  = tx_on ? 8'(`HFM_TONE_MID + 8'(clip_s)) : `HFM_TONE_MID;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q   <= '0;
      tone_q <= '{level: `HFM_TONE_MID, enable: 1'b0};
    end else begin
      ph_q   <= ph_d;
      tone_q <= tone_d;
    end
  end
  assign analog_tone_out = tone_q;

  // ----------------------------------------
  // receiver: half-period discriminator and carrier gate
  // ----------------------------------------
  logic        rxc_d1_q, bit_q, bit_d, car_q, car_d, rxd_q, rxd_d;
  logic [15:0] hp_q, hp_d;
  always_comb begin
    bit_d = bit_q;
    hp_d  = (hp_q == 16'hffff) ? hp_q : hp_q + 16'd1;
    if (pin_s.rx_cmp != rxc_d1_q) begin
      // long half period is mark; edge-timed so jitter stays within a cycle
      bit_d = (hp_q >= SPLIT);
      hp_d  = '0;
    end
    car_d = pin_s.carrier_cmp & cfg_q[`HFM_CFG_RX_EN];
    rxd_d = car_d ? bit_d : 1'b1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxc_d1_q <= 1'b0;
      bit_q    <= 1'b1;
      hp_q     <= '0;
      car_q    <= 1'b0;
      rxd_q    <= 1'b1;
    end else begin
      rxc_d1_q <= pin_s.rx_cmp;
      bit_q    <= bit_d;
      hp_q     <= hp_d;
      car_q    <= car_d;
      rxd_q    <= rxd_d;
    end
  end
  assign carrier_detect_out = car_q;
  assign rxd                = rxd_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wait_done;
    sv_q == SV_WAIT && sv_cnt_q == POR_LAST && pin_s.supervisor_sense_input;
  endsequence
  sequence s_cfg_frame;
    sel_rise && nb_q == `HFM_SER_BITS && sh_q[`HFM_SER_SEL] && sv_q == SV_RUN;
  endsequence
  property p_sv_release;
    s_wait_done |=> sv_q == SV_RUN ##0 !supervisor_reset_n_oe;
  endproperty
  a_sv_release: assert property (p_sv_release) else $error("reset not released");
  property p_sv_early;
    $fell(supervisor_reset_n_oe) |-> $past(sv_cnt_q) == POR_LAST;
  endproperty
  a_sv_early: assert property (p_sv_early) else $error("reset released early");
  property p_sv_hold;
    !pin_s.supervisor_sense_input |=> supervisor_reset_n_oe && !supervisor_reset_n_o;
  endproperty
  a_sv_hold: assert property (p_sv_hold) else $error("reset not driven low");
  property p_cfg_clear;
    sv_q != SV_RUN |=> cfg_q == `HFM_CFG_RST;
  endproperty
  a_cfg_clear: assert property (p_cfg_clear) else $error("config not cleared");
  property p_cfg_load;
    s_cfg_frame |=> cfg_q == $past(sh_q[7:0]);
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("config word not loaded");
  property p_tx_off;
    pin_s.request_to_send_n |=> !tone_q.enable && tone_q.level == `HFM_TONE_MID;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("transmitter not off");
  property p_tone_step;
    rst_n |=> ph_q == $past(ph_q) + ($past(pin_s.txd) ? MARK_INC : SPACE_INC);
  endproperty
  a_tone_step: assert property (p_tone_step) else $error("tone step wrong");
  property p_no_carrier;
    !pin_s.carrier_cmp |=> !carrier_detect_out ##0 rxd;
  endproperty
  a_no_carrier: assert property (p_no_carrier) else $error("carrier or idle wrong");
  property p_carrier;
    pin_s.carrier_cmp && cfg_q[`HFM_CFG_RX_EN] |=> carrier_detect_out;
  endproperty
  a_carrier: assert property (p_carrier) else $error("carrier not detected");
  property p_dac_off;
    !cfg_q[`HFM_CFG_DAC_EN] |=> !dac_out;
  endproperty
  a_dac_off: assert property (p_dac_off) else $error("dac active while off");
endmodule : hfm_modem
`default_nettype wire

// >>> design/hfm_pkg.sv
package hfm_pkg;

  // pin levels that arrive from outside the clock domain
  typedef struct packed {
    logic ext_clk_sel;
    logic supervisor_sense_input;
    logic rx_cmp;
    logic carrier_cmp;
    logic txd;
    logic request_to_send_n;
    logic ser_clk;
    logic ser_data;
    logic ser_sel_n;
  } hfm_pins_t;

  typedef struct packed {
    logic [7:0] level;
    logic       enable;
  } hfm_tone_t;

  typedef enum logic [2:0] {
    SV_HOLD = 3'b001,
    SV_WAIT = 3'b010,
    SV_RUN  = 3'b100
  } hfm_sv_state_t;

endpackage : hfm_pkg

// >>> tb/hfm_host.sv
`timescale 1ns/1ps
`default_nettype none
module hfm_host (
  // clock
  input  wire logic clk,
  // host lines
  output logic      txd,
  output logic      request_to_send_n,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      ser_sel_n
);
  initial begin
    txd               = 1'b1;
    request_to_send_n = 1'b1;
    ser_clk           = 1'b0;
    ser_data          = 1'b0;
    ser_sel_n         = 1'b1;
  end
  task automatic w4();
    repeat (4) @(negedge clk);
  endtask : w4
  // n bits msb first, slow serial clock
  task automatic send(input logic [23:0] w, input int n);
    ser_sel_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      ser_data = w[i];
      w4();
      ser_clk = 1'b1;
      w4();
      ser_clk = 1'b0;
    end
    w4();
    ser_sel_n = 1'b1;
    ser_data  = ~ser_data;
    w4();
    w4();
  endtask : send
  // request to send is set to rts_n before the bit level
  task automatic tx(input logic b, input logic rts_n);
    request_to_send_n = rts_n;
    @(negedge clk);
    txd               = b;
  endtask : tx
endmodule : hfm_host
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hfm_pkg::*;
  localparam int POR = 20;
  logic       clk, resetn, ext, sense, rxc, cdc;
  logic       txd, rtsn, sck, sdo, ssn;
  hfm_pins_t  pins;
  hfm_tone_t  tone;
  logic       oe_o, oe, car_det, rxd, dac, mclk, opd, rst_pin;
  int         miscompares, cmp_count;
  logic [7:0] mx, mn;
  assign pins    = '{ext, sense, rxc, cdc, txd, rtsn, sck, sdo, ssn};
  assign rst_pin = oe ? oe_o : 1'b1;
  hfm_host h (.clk(clk), .txd(txd), .request_to_send_n(rtsn),
              .ser_clk(sck), .ser_data(sdo), .ser_sel_n(ssn));
  hfm_modem #(.POR_CYCLES(POR)) dut_u (
    .clk(clk), .resetn(resetn), .pins(pins),
    .supervisor_reset_n_o(oe_o), .supervisor_reset_n_oe(oe),
    .carrier_detect_out(car_det), .rxd(rxd), .analog_tone_out(tone),
    .dac_out(dac), .secondary_clock_out(mclk), .osc_power_down(opd));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_in(input int v, input int lo, input int hi);
    // in range compares equal; out of range reports against the low bound
    chk(32'(v), (v >= lo && v <= hi) ? 32'(v) : 32'(lo));
  endtask : chk_in
  task automatic tally_and_finish();
    if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      chk(32'(n), 32'(lim - 1));
      tally_and_finish();
    end
  endtask : bound
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  // cycles to the next midscale crossing of the tone
  task automatic hp(output int n);
    logic s;
    s = tone.level[7];
    n = 0;
    while (tone.level[7] === s && n < 40000) begin
      @(negedge clk);
      n++;
      if (tone.level > mx) mx = tone.level;
      if (tone.level < mn) mn = tone.level;
    end
    bound(n, 40000);
  endtask : hp
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    w(2);
    chk(rst_pin, 1'b0);
    chk(rxd, 1'b1);
    chk(car_det, 1'b0);
    chk(tone, 9'h100);
    chk(dac, 1'b0);
  endtask : t_reset
  task automatic t_sup();
    int n;
    sense = 1'b1;
    n = 0;
    while (oe !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    bound(n, 200);
    chk_in(n, POR + 1, POR + 6);
    chk(rst_pin, 1'b1);
  endtask : t_sup
  task automatic t_rate();
    int rt[4] = '{460800, 921600, 1840000, 3680000};
    int n;
    logic p;
    for (int r = 0; r < 4; r++) begin
      h.send(24'h800000 | 24'(r << 4), 24);
      n = 0;
      p = mclk;
      repeat (1000) begin
        @(negedge clk);
        if (mclk && !p) n++;
        p = mclk;
      end
      chk_in(n, rt[r] / 40000 - 1, rt[r] / 40000 + 2);
    end
    ext = 1'b1;
    w(4);
    chk(opd, 1'b1);
  endtask : t_rate
  task automatic t_rx();
    h.send(24'h800002, 24);
    cdc = 1'b1;
    w(5);
    chk(car_det, 1'b1);
    rxc = 1'b1;
    w(9000);
    rxc = 1'b0;
    w(5);
    chk(rxd, 1'b0);
    w(6500);
    chk(rxd, 1'b0);
    w(6500);
    rxc = 1'b1;
    w(5);
    chk(rxd, 1'b1);
    w(4500);
    chk(rxd, 1'b1);
    w(4500);
    rxc = 1'b0;
    w(5);
    chk(rxd, 1'b0);
    cdc = 1'b0;
    w(5);
    chk(car_det, 1'b0);
    chk(rxd, 1'b1);
  endtask : t_rx
  task automatic t_dac();
    int n;
    h.send(24'h004000, 24);
    h.send(24'h800004, 24);
    n = 0;
    repeat (4000) begin
      @(negedge clk);
      if (dac) n++;
    end
    chk_in(n, 980, 1020);
  endtask : t_dac
  task automatic t_tx();
    int n;
    h.send(24'h800001, 24);
    w(5);
    chk(tone, 9'h100);
    h.tx(1'b1, 1'b0);
    w(5);
    chk(tone.enable, 1'b1);
    h.send(24'h800000, 23);
    chk(tone.enable, 1'b1);
    mx = 8'h80;
    mn = 8'h80;
    hp(n);
    hp(n);
    chk_in(n, 16167, 17167);
    hp(n);
    chk_in(n, 16167, 17167);
    chk(mx, 8'he0);
    chk(mn, 8'h20);
    h.tx(1'b0, 1'b0);
    hp(n);
    hp(n);
    chk_in(n, 8818, 9364);
    sense = 1'b0;
    w(6);
    chk(tone, 9'h100);
    sense = 1'b1;
    w(POR + 8);
    chk(tone.enable, 1'b0);
  endtask : t_tx
  initial begin
    resetn      = 1'b0;
    ext         = 1'b0;
    sense       = 1'b0;
    rxc         = 1'b0;
    cdc         = 1'b0;
    miscompares = 0;
    cmp_count   = 0;
    w(2);
    resetn = 1'b1;
    t_reset();
    t_sup();
    t_rate();
    t_rx();
    t_dac();
    t_tx();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
